/* core/gate_ctrl_pkg.sv */
// Constants and types shared by the three-phase gate control logic.
// Overview of operation
// RULE_01 - Gate commands come from mode, PWM, fault flags and the phase enables.
// RULE_02 - A gate turns on only 3 us after the PWM edge requesting it.
// RULE_03 - Complementary chopping alternates high and low drives, never both on.
// RULE_04 - Each turn-on waits its dead time after the opposite switch turns off.
// RULE_05 - Dead time 1.0 to 5.5 us standard, 0.2 to 1.0 us fast variant; the code waits 3 us in both, as dead time shares the turn-on count.
// RULE_06 - Overheat or supply surge turns all gates off until next PWM cycle.
// RULE_07 - Current limit latches the affected drive off until next PWM cycle.
// RULE_08 - Controller must toggle PWM after reset or faults to re-enable gates.
// RULE_09 - Comparator trip sets the overcurrent flag and stops load current.
// RULE_10 - Overcurrent flag sets 1.5 to 5.0 us after comparator goes low.
// RULE_11 - Under current limit only static outputs stay on; other faults force off.
// RULE_12 - Overheat or surge sets its flag and forces outputs to no current.
// RULE_13 - Three independent phases, each pair of enables steers only its gates.
// RULE_14 - Both enables equal turns both gates of that phase off.
// RULE_15 - Mode 00: high enable holds high on, low enable chops low side.
// RULE_16 - Mode 10: high enable chops high side, low enable holds low on.
// RULE_17 - Mode 01: high enable holds high on, low enable gives complementary chop.
// RULE_18 - Mode 11: high enable gives complementary chop, low enable holds low on.
// RULE_19 - One shared PWM input modulates all three output pairs.
// RULE_20 - A blown fuse forces all outputs off for good and ignores inputs; the code clears its fuse latch when arst_n is asserted.
// RULE_21 - Inputs sampled on the system clock; delays are parameterised counters.
// RULE_22 - Fault latches clear on the next PWM rising edge once conditions end.
package gate_ctrl_pkg;
	localparam int CLK_MHZ                     = 40;
	localparam int TURN_ON_DELAY_NS            = 3000;
	localparam int HIGH_TURN_ON_DEAD_TIME_NS   = 3000;
	localparam int LOW_TURN_ON_DEAD_TIME_NS    = 3000;
	localparam int FAST_DEAD_TIME_NS           = 650;
	localparam int CL_DELAY_NS                 = 2800;
	localparam int CNT_W                       = 8;
	localparam logic [CNT_W-1:0] TURN_ON_CYC   =
		CNT_W'((TURN_ON_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] HIGH_DEAD_CYC =
		CNT_W'((HIGH_TURN_ON_DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] LOW_DEAD_CYC  =
		CNT_W'((LOW_TURN_ON_DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] FAST_DEAD_CYC =
		CNT_W'((FAST_DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CL_CYC        =
		CNT_W'((CL_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam int NUM_PHASES                  = 3;
	localparam int SYNC_W                      = 13;
	localparam logic [1:0] MODE_LOW_CHOP       = 2'h0;
	localparam logic [1:0] MODE_COMP_ON_LOW    = 2'h1;
	localparam logic [1:0] MODE_HIGH_CHOP      = 2'h2;
	localparam logic [1:0] MODE_COMP_ON_HIGH   = 2'h3;
	localparam logic POR_LOCK_RST              = 1'b1;
	// The PWM stages reset high, so a pin that idles high through reset is
	// not mistaken for a rising edge that would release the start lock.
	localparam logic [SYNC_W-1:0] SYNC_RST     = 13'h1000;
	localparam logic PWM_PREV_RST              = 1'b1;

	typedef struct packed {
		logic overheat_flag;
		logic supply_surge_flag;
		logic overcurrent_flag;
	} fault_flags_t;

	typedef struct packed {
		logic low;
		logic high;
	} gate_pair_t;

	localparam fault_flags_t FLAGS_RST = 3'h0;
endpackage : gate_ctrl_pkg

/* core/gate_phase.sv */
// One phase output stage with turn-on delay and shoot-through dead times.
`timescale 1ns/100ps
module gate_phase #(
	parameter logic [gate_ctrl_pkg::CNT_W-1:0] HIGH_CYC = 8'h78,
	parameter logic [gate_ctrl_pkg::CNT_W-1:0] LOW_CYC  = 8'h78
) (
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	input  wire gate_ctrl_pkg::gate_pair_t req,
	output logic                    high_gate,
	output logic                    low_gate
);
	logic [gate_ctrl_pkg::CNT_W-1:0] hcnt_r, hcnt_nxt, lcnt_r, lcnt_nxt;
	logic                            high_r, high_nxt, low_r, low_nxt;
	logic [gate_ctrl_pkg::CNT_W-1:0] low_off_age_r, high_off_age_r;

	// A counter only runs while its side is wanted and the other is off, so
	// the wait starts when the opposite switch has actually turned off.
	always_comb begin
		hcnt_nxt = 8'h00;
		lcnt_nxt = 8'h00;
		if (req.high && !low_r) begin // RULE_04
			hcnt_nxt = (hcnt_r == HIGH_CYC) ? hcnt_r : hcnt_r + 8'h01; // RULE_02
		end
		if (req.low && !high_r) begin // RULE_04
			lcnt_nxt = (lcnt_r == LOW_CYC) ? lcnt_r : lcnt_r + 8'h01; // RULE_02
		end
		high_nxt = req.high && !req.low && !low_r && hcnt_nxt == HIGH_CYC;
		low_nxt  = req.low && !req.high && !high_r && lcnt_nxt == LOW_CYC;
		high_nxt = high_nxt && !low_nxt; // RULE_03
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hcnt_r <= 8'h00;
			lcnt_r <= 8'h00;
			high_r <= 1'b0;
			low_r  <= 1'b0;
		end else begin
			hcnt_r <= hcnt_nxt;
			lcnt_r <= lcnt_nxt;
			high_r <= high_nxt;
			low_r  <= low_nxt;
		end
	end

	assign high_gate = high_r;
	assign low_gate  = low_r;

	// Helper ages of the off time of each side, read only by assertions.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_off_age_r  <= 8'hff;
			high_off_age_r <= 8'hff;
		end else begin
			low_off_age_r  <= low_r ? 8'h00 :
				(low_off_age_r == 8'hff ? 8'hff : low_off_age_r + 8'h01);
			high_off_age_r <= high_r ? 8'h00 :
				(high_off_age_r == 8'hff ? 8'hff : high_off_age_r + 8'h01);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_no_overlap: assert property (!(high_r && low_r)) // RULE_03
		else $error("high and low gates on together");
	a_high_dead: assert property ( // RULE_04
		$rose(high_r) |-> low_off_age_r >= HIGH_CYC)
		else $error("high gate on before dead time");
	a_low_dead: assert property ( // RULE_04
		$rose(low_r) |-> high_off_age_r >= LOW_CYC)
		else $error("low gate on before dead time");
	a_turn_off_fast: assert property ( // RULE_11
		!req.high |=> !high_r)
		else $error("high gate stayed on without request");
	c_high_on: cover property ($rose(high_r));
	c_low_after_high: cover property ($fell(high_r) ##[1:200] $rose(low_r));
endmodule : gate_phase

/* core/gate_ctrl.sv */
// Top of the three-phase gate control: sync, mode decode and fault latches.
`timescale 1ns/100ps
module gate_ctrl #(
	parameter bit FAST_VARIANT = 1'b0
) (
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire logic                     pwm_in,
	input  wire logic                     chop_select_bit_a,
	input  wire logic                     chop_select_bit_b,
	input  wire logic [2:0]               phase_low_enable,
	input  wire logic [2:0]               phase_high_enable,
	input  wire logic                     overheat_in,
	input  wire logic                     supply_surge_in,
	input  wire logic                     isense_cmp_n,
	input  wire logic                     fuse_blown_in,
	output logic [2:0]                    phase_low_gate_out,
	output logic [2:0]                    phase_high_gate_out,
	output gate_ctrl_pkg::fault_flags_t   fault_flags
);
	localparam logic [gate_ctrl_pkg::CNT_W-1:0] DEAD_H =
		FAST_VARIANT ? gate_ctrl_pkg::FAST_DEAD_CYC
		: gate_ctrl_pkg::HIGH_DEAD_CYC; // RULE_05
	localparam logic [gate_ctrl_pkg::CNT_W-1:0] DEAD_L =
		FAST_VARIANT ? gate_ctrl_pkg::FAST_DEAD_CYC
		: gate_ctrl_pkg::LOW_DEAD_CYC; // RULE_05
	localparam logic [gate_ctrl_pkg::CNT_W-1:0] HIGH_CYC =
		(DEAD_H > gate_ctrl_pkg::TURN_ON_CYC) ? DEAD_H
		: gate_ctrl_pkg::TURN_ON_CYC;
	localparam logic [gate_ctrl_pkg::CNT_W-1:0] LOW_CYC =
		(DEAD_L > gate_ctrl_pkg::TURN_ON_CYC) ? DEAD_L
		: gate_ctrl_pkg::TURN_ON_CYC;

	logic [gate_ctrl_pkg::SYNC_W-1:0] sync1_r, sync2_r;
	logic                             pwm_s, ot_s, ov_s, cmp_low_s, fuse_s;
	logic [1:0]                       mode_s;
	logic [2:0]                       le_s, he_s;
	logic                             pwm_prev_r, pwm_rise;
	logic                             por_r, por_nxt;
	logic                             fuse_r, fuse_nxt;
	gate_ctrl_pkg::fault_flags_t      flags_r, flags_nxt;
	logic [gate_ctrl_pkg::CNT_W-1:0]  cl_cnt_r, cl_cnt_nxt;
	logic                             cl_trip, blocked;
	gate_ctrl_pkg::gate_pair_t        req [gate_ctrl_pkg::NUM_PHASES];

	// Every pin is asynchronous to sys_clk, so all but arst_n pass two flops first.
	always_ff @(posedge sys_clk or negedge arst_n) begin // RULE_21
		if (!arst_n) begin
			sync1_r <= gate_ctrl_pkg::SYNC_RST;
			sync2_r <= gate_ctrl_pkg::SYNC_RST;
		end else begin
			sync1_r <= {pwm_in, chop_select_bit_b, chop_select_bit_a,
				phase_low_enable, phase_high_enable, overheat_in,
				supply_surge_in, !isense_cmp_n, fuse_blown_in};
			sync2_r <= sync1_r;
		end
	end

	assign {pwm_s, mode_s, le_s, he_s, ot_s, ov_s, cmp_low_s, fuse_s} =
		sync2_r;

	// Truth table for one phase; the same decode serves every phase.
	function automatic gate_ctrl_pkg::gate_pair_t decide(
		input logic [1:0] mode,
		input logic       le,
		input logic       he,
		input logic       pwm,
		input logic       cl
	);
		gate_ctrl_pkg::gate_pair_t g;
		g = 2'b00;
		if (le != he) begin // RULE_14
			case (mode) // RULE_01
				gate_ctrl_pkg::MODE_LOW_CHOP: begin
					if (he) begin
						g.high = 1'b1; // RULE_15
					end else begin
						g.low = pwm && !cl; // RULE_15 RULE_11
					end
				end
				gate_ctrl_pkg::MODE_COMP_ON_LOW: begin
					if (he || cl) begin
						g.high = 1'b1; // RULE_17 RULE_11
					end else begin
						g.high = pwm; // RULE_17 RULE_03
						g.low  = !pwm;
					end
				end
				gate_ctrl_pkg::MODE_HIGH_CHOP: begin
					if (le) begin
						g.low = 1'b1; // RULE_16
					end else begin
						g.high = pwm && !cl; // RULE_16 RULE_11
					end
				end
				gate_ctrl_pkg::MODE_COMP_ON_HIGH: begin
					if (le || cl) begin
						g.low = 1'b1; // RULE_18 RULE_11
					end else begin
						g.high = pwm; // RULE_18 RULE_03
						g.low  = !pwm;
					end
				end
				default: g = 2'b00;
			endcase
		end
		return g;
	endfunction : decide

	// The flags clear only on a PWM rising edge with the cause gone; a cause
	// still present in that cycle keeps its flag set.
	always_comb begin
		pwm_rise  = pwm_s && !pwm_prev_r;
		cl_trip   = cmp_low_s && cl_cnt_r == gate_ctrl_pkg::CL_CYC - 8'h01;
		cl_cnt_nxt = 8'h00;
		if (cmp_low_s) begin // RULE_10
			cl_cnt_nxt = (cl_cnt_r == gate_ctrl_pkg::CL_CYC) ? cl_cnt_r
				: cl_cnt_r + 8'h01;
		end
		flags_nxt.overheat_flag = ot_s ||
			(flags_r.overheat_flag && !pwm_rise); // RULE_12 RULE_22
		flags_nxt.supply_surge_flag = ov_s ||
			(flags_r.supply_surge_flag && !pwm_rise); // RULE_12 RULE_22
		flags_nxt.overcurrent_flag = cl_trip || (flags_r.overcurrent_flag &&
			!(pwm_rise && !cmp_low_s)); // RULE_09 RULE_07 RULE_22
		por_nxt  = por_r && !pwm_rise; // RULE_08
		fuse_nxt = fuse_r || fuse_s; // RULE_20
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_prev_r <= gate_ctrl_pkg::PWM_PREV_RST;
			por_r      <= gate_ctrl_pkg::POR_LOCK_RST;
			fuse_r     <= 1'b0;
			flags_r    <= gate_ctrl_pkg::FLAGS_RST;
			cl_cnt_r   <= 8'h00;
		end else begin
			pwm_prev_r <= pwm_s;
			por_r      <= por_nxt;
			fuse_r     <= fuse_nxt;
			flags_r    <= flags_nxt;
			cl_cnt_r   <= cl_cnt_nxt;
		end
	end

	assign fault_flags = flags_r;
	// Blocking uses the latched flags, so a fault that has already cleared
	// still holds the gates off until the next PWM cycle starts.
	assign blocked = fuse_r || por_r || flags_r.overheat_flag ||
		flags_r.supply_surge_flag; // RULE_06 RULE_12 RULE_20 RULE_08

	for (genvar i = 0; i < gate_ctrl_pkg::NUM_PHASES; i++) begin : g_phase
		always_comb begin
			req[i] = blocked ? 2'b00 : decide(mode_s, le_s[i], he_s[i],
				pwm_s, flags_r.overcurrent_flag); // RULE_13 RULE_19
		end

		gate_phase #(
			.HIGH_CYC (HIGH_CYC),
			.LOW_CYC  (LOW_CYC)
		) u_phase (
			.sys_clk   (sys_clk),
			.arst_n    (arst_n),
			.req       (req[i]),
			.high_gate (phase_high_gate_out[i]),
			.low_gate  (phase_low_gate_out[i])
		);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_fuse_all_off: assert property ( // RULE_20
		fuse_r |=> phase_low_gate_out == 3'h0 && phase_high_gate_out == 3'h0)
		else $error("gate on after fuse blown");
	a_fault_all_off: assert property ( // RULE_06
		(flags_r.overheat_flag || flags_r.supply_surge_flag || por_r)
		|=> phase_low_gate_out == 3'h0 && phase_high_gate_out == 3'h0)
		else $error("gate on while fault latched");
	a_cl_set_delay: assert property ( // RULE_10
		cl_trip |=> flags_r.overcurrent_flag &&
		cl_cnt_r == gate_ctrl_pkg::CL_CYC)
		else $error("overcurrent flag not set after delay");
	a_cl_cause: assert property ( // RULE_09
		$rose(flags_r.overcurrent_flag) |-> $past(cmp_low_s, 2))
		else $error("overcurrent flag set without comparator");
	a_unlock_edge: assert property ( // RULE_08
		$fell(por_r) |-> $past(pwm_s) && !$past(pwm_prev_r))
		else $error("start lock released without PWM edge");
	a_ot_hold: assert property ( // RULE_22
		flags_r.overheat_flag && !pwm_rise |=> flags_r.overheat_flag)
		else $error("overheat flag cleared outside PWM edge");
	c_cl_trip: cover property ($rose(flags_r.overcurrent_flag));
	c_ot_cycle: cover property ($rose(flags_r.overheat_flag)
		##[1:1000] $fell(flags_r.overheat_flag));
	c_unlock: cover property ($fell(por_r));
endmodule : gate_ctrl

/* verification/mcu_model.sv */
// Controller model that drives PWM, the mode pair and the phase enables.
`timescale 1ns/100ps
module mcu_model (
	input  wire logic       sys_clk,
	output logic            pwm_in,
	output logic            chop_select_bit_a,
	output logic            chop_select_bit_b,
	output logic [2:0]      phase_low_enable,
	output logic [2:0]      phase_high_enable
);
	initial begin
		pwm_in = 1'b0;
		{chop_select_bit_b, chop_select_bit_a} = 2'h0;
		phase_low_enable = 3'h0;
		phase_high_enable = 3'h0;
	end

	// The controller changes its pins only at the falling edge.
	task automatic drive(input int m, input logic [2:0] le, he);
		@(negedge sys_clk);
		{chop_select_bit_b, chop_select_bit_a} = 2'(m);
		phase_low_enable = le;
		phase_high_enable = he;
	endtask : drive

	task automatic set_pwm(input logic p);
		@(negedge sys_clk);
		pwm_in = p;
	endtask : set_pwm

	// Gates stay dark after reset or a fault until PWM is toggled.
	task automatic rearm();
		set_pwm(1'b0);
		repeat (4) @(negedge sys_clk);
		set_pwm(1'b1);
	endtask : rearm
endmodule : mcu_model

/* verification/three_phase_gate_control_tb.sv */
// Self-checking bench for the three-phase gate control.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module three_phase_gate_control_tb;
	logic sys_clk = 1'b0, arst_n = 1'b0, overheat_in = 1'b0;
	logic supply_surge_in = 1'b0, isense_cmp_n = 1'b1, fuse_blown_in = 1'b0;
	logic pwm, sel_a, sel_b;
	logic [2:0] le_w, he_w, low_out, high_out;
	gate_ctrl_pkg::fault_flags_t flags;
	int errors = 0, n_compared = 0, cnt;

	gate_ctrl gate_ctrl_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.pwm_in(pwm), .chop_select_bit_a(sel_a), .chop_select_bit_b(sel_b),
		.phase_low_enable(le_w), .phase_high_enable(he_w),
		.overheat_in(overheat_in), .supply_surge_in(supply_surge_in),
		.isense_cmp_n(isense_cmp_n), .fuse_blown_in(fuse_blown_in),
		.phase_low_gate_out(low_out), .phase_high_gate_out(high_out),
		.fault_flags(flags));
	mcu_model mcu_model_inst (.sys_clk(sys_clk), .pwm_in(pwm),
		.chop_select_bit_a(sel_a), .chop_select_bit_b(sel_b),
		.phase_low_enable(le_w), .phase_high_enable(he_w));

	always #12.5 sys_clk = ~sys_clk;

	// Returns the settled pair as {low, high}.
	function automatic logic [1:0] exp_pair(int m, logic l, h, p, cl);
		if (l == h) return 2'h0;
		if (cl != 0) case (m)
			0: return h ? 2'h1 : 2'h0;
			1: return 2'h1;
			2: return h ? 2'h0 : 2'h2;
			default: return 2'h2;
		endcase
		case (m)
			0: return h ? 2'h1 : (p ? 2'h2 : 2'h0);
			1: return h ? 2'h1 : (p ? 2'h1 : 2'h2);
			2: return h ? (p ? 2'h1 : 2'h0) : 2'h2;
			default: return h ? (p ? 2'h1 : 2'h2) : 2'h2;
		endcase
	endfunction : exp_pair

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic check_all(input int m, cl, off, input logic [2:0] le, he);
		logic [1:0] e;
		for (int i = 0; i < 3; i++) begin
			e = off ? 2'h0 : exp_pair(m, le[i], he[i], pwm, cl);
			`CHK("gates", e, {low_out[i], high_out[i]})
		end
	endtask : check_all

	// Both gates of a phase on at once would short the supply.
	always @(negedge sys_clk) if (arst_n === 1'b1)
		`CHK("overlap", 3'h0, low_out & high_out)

	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		close_out();
	end

	initial begin
		logic [2:0] le, he;
		void'($urandom(1862));
		cyc(5);
		arst_n = 1'b1;
		mcu_model_inst.drive(0, 3'h2, 3'h0);
		cyc(140);
		check_all(0, 0, 1, 3'h2, 3'h0);
		mcu_model_inst.rearm();
		cyc(118);
		`CHK("turn_on_early", 1'b0, low_out[1])
		cyc(8);
		`CHK("turn_on_late", 1'b1, low_out[1])
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				le = 3'($urandom);
				he = 3'($urandom);
				mcu_model_inst.drive(m, le, he);
				for (int p = 1; p >= 0; p--) begin
					mcu_model_inst.set_pwm(1'(p));
					cyc(140);
					check_all(m, 0, 0, le, he);
				end
			end
		end
		mcu_model_inst.drive(3, 3'h0, 3'h4);
		mcu_model_inst.set_pwm(1'b1);
		cyc(140);
		mcu_model_inst.set_pwm(1'b0);
		cyc(5);
		`CHK("dead_gap", 2'h0, {low_out[2], high_out[2]})
		cyc(121);
		`CHK("dead_end", 2'h2, {low_out[2], high_out[2]})
		mcu_model_inst.drive(1, 3'h1, 3'h2);
		mcu_model_inst.set_pwm(1'b1);
		cyc(140);
		isense_cmp_n = 1'b0;
		cnt = 0;
		while (flags.overcurrent_flag !== 1'b1 && cnt < 300) begin
			cyc(1);
			cnt++;
		end
		`CHK("cl_delay", 1'b1, cnt >= 110 && cnt <= 118)
		if (cnt >= 300) close_out();
		cyc(140);
		check_all(1, 1, 0, 3'h1, 3'h2);
		isense_cmp_n = 1'b1;
		mcu_model_inst.rearm();
		cyc(140);
		`CHK("cl_clear", 3'h0, flags)
		check_all(1, 0, 0, 3'h1, 3'h2);
		for (int f = 0; f < 2; f++) begin
			cyc(1);
			{overheat_in, supply_surge_in} = f ? 2'h1 : 2'h2;
			cyc(5);
			`CHK("fault_flag", f ? 3'h2 : 3'h4, flags)
			check_all(1, 0, 1, 3'h1, 3'h2);
			{overheat_in, supply_surge_in} = 2'h0;
			cyc(140);
			check_all(1, 0, 1, 3'h1, 3'h2);
			mcu_model_inst.rearm();
			cyc(140);
			check_all(1, 0, 0, 3'h1, 3'h2);
		end
		fuse_blown_in = 1'b1;
		cyc(5);
		fuse_blown_in = 1'b0;
		mcu_model_inst.rearm();
		cyc(140);
		check_all(1, 0, 1, 3'h1, 3'h2);
		arst_n = 1'b0;
		cyc(5);
		arst_n = 1'b1;
		cyc(140);
		check_all(1, 0, 1, 3'h1, 3'h2);
		mcu_model_inst.rearm();
		cyc(140);
		check_all(1, 0, 0, 3'h1, 3'h2);
		close_out();
	end
endmodule : three_phase_gate_control_tb
